// file: core/eq_serial_params.svh
`ifndef EQ_SERIAL_PARAMS_SVH
`define EQ_SERIAL_PARAMS_SVH

// Length of the shadow chain and of one programming word.
`define CHAIN_LEN 21
// Number of equalizer channels and width of one boost code.
`define CHANNELS 4
`define CODE_W 5
// Width of all boost codes packed together.
`define CODES_W 20
// Bit position of the override bit (register 1) in the packed word.
`define OVERRIDE_POS 0
// Bit position of the first boost bit (register 2) in the packed word.
`define FIRST_CODE_POS 1
// Width and top value of the host bit counter.
`define BIT_CNT_W 5
`define BIT_CNT_LAST 5'h14
// Width of the device commit counter.
`define COMMIT_CNT_W 8
// Reset values.
`define OVERRIDE_RESET 1'h0
`define WORD_RESET 21'h000000
`define CODES_RESET 20'h00000
// System clock and shift clock timing.
`define SYS_CLK_HZ 10000000
`define SYS_CLK_NS 100
`define SHIFT_MAX_HZ 20000000
`define SHIFT_TYP_HZ 10000000
// Host shift clock is the system clock divided by this even figure.
`define SHIFT_DIV 2
// Least setup from enable fall to first rise, and hold before enable rise.
`define T_SETUP_NS 100
`define T_HOLD_NS 100
`define SETUP_CYCLES ((`T_SETUP_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define HOLD_CYCLES ((`T_HOLD_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define WAIT_CNT_W 4

`endif

// file: core/eq_serial_pkg.sv
`include "eq_serial_params.svh"
`default_nettype none

package eq_serial_pkg;

    typedef logic [`CODE_W-1:0] boost_code_type;
    typedef logic [`CHAIN_LEN-1:0] config_word_type;

    typedef enum logic [4:0] {
        HOST_IDLE = 5'b00001,
        HOST_SETUP = 5'b00010,
        HOST_SHIFT = 5'b00100,
        HOST_HOLD = 5'b01000,
        HOST_RELEASE = 5'b10000
    } host_state_type;

endpackage

`default_nettype wire

// file: core/eq_serial_if.sv
`timescale 1ns/100ps
`default_nettype none

interface eq_serial_if;
    logic load_enable_n;
    logic shift_clk;
    logic serial_data_in;
    logic serial_data_out;

    modport host (
        output load_enable_n,
        output shift_clk,
        output serial_data_in,
        input serial_data_out
    );

    modport device (
        input load_enable_n,
        input shift_clk,
        input serial_data_in,
        output serial_data_out
    );
endinterface

`default_nettype wire

// file: core/eq_serial_device.sv
// Behaviour
// R1: Enable low shifts data, active config untouched.
// R2: Sample data on rising shift clock; 21+ bits.
// R3: Extra bits push older ones out; keep last 21.
// R4: Host sends register 21 first, register 1 last.
// R5: Host shift clock at most 20MHz.
// R6: Enable rise copies shadow chain to active registers.
// R7: New bit enters stage 1, moves upward.
// R8: Stage 21 drives serial output same cycle.
// R9: First 20 output bits after enable fall undefined.
// R10: Separate enables: only one device enabled.
// R11: Daisy chain: common enable, output feeds input.
// R12: Override set selects register boosts, else straps.
// R13: Boost codes from registers 2-21, LSB first.
// R14: Override bit zero after power-up.
// R15: Chain of N devices gets 21 times N bits.
`include "eq_serial_params.svh"
`timescale 1ns/100ps
`default_nettype none

module eq_serial_device (
    eq_serial_if.device link,
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [`CODES_W-1:0] i_boost_strap_pins,
    output logic [`CODES_W-1:0] o_boost_level,
    output logic [`CHANNELS-1:0] o_boost_from_regs,
    output logic o_override,
    output logic o_commit,
    output logic o_loaded,
    output logic [`COMMIT_CNT_W-1:0] o_commit_count,
    output logic [`CHAIN_LEN-1:0] o_active_word
);

    // Packed boost code of one channel out of a full register word.
    function automatic eq_serial_pkg::boost_code_type code_of(
        input eq_serial_pkg::config_word_type word,
        input int channel
    );
        eq_serial_pkg::boost_code_type code;
        code = word[`FIRST_CODE_POS + channel * `CODE_W +: `CODE_W];
        return code;
    endfunction

    // Strap code of one channel out of the synchronised strap pins.
    function automatic eq_serial_pkg::boost_code_type strap_of(
        input logic [`CODES_W-1:0] straps,
        input int channel
    );
        eq_serial_pkg::boost_code_type code;
        code = straps[channel * `CODE_W +: `CODE_W];
        return code;
    endfunction

    // Shadow chain, bit k holds stage k+1; runs on the link clock.
    eq_serial_pkg::config_word_type shadow;
    logic data_out;

    // Enable crossing into the system clock domain.
    logic enable_n_meta;
    logic enable_n_sync;
    logic enable_n_prev;
    logic commit_now;

    // Strap pins crossing into the system clock domain.
    logic [`CODES_W-1:0] strap_meta;
    logic [`CODES_W-1:0] strap_sync;

    // Active registers.
    eq_serial_pkg::config_word_type active;
    logic loaded;
    logic [`COMMIT_CNT_W-1:0] commit_count;
    logic [`CODES_W-1:0] next_boost;
    logic [`CHANNELS-1:0] next_from_regs;
    logic [`CODES_W-1:0] boost_level;
    logic [`CHANNELS-1:0] from_regs;

    // Shift only while the enable is low at the rising link edge.
    always_ff @(posedge link.shift_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shadow <= `WORD_RESET;
        end else if (!link.load_enable_n) begin // R1
            // Newest bit into stage 1, every other bit one stage up.
            shadow <= {shadow[`CHAIN_LEN-2:0], link.serial_data_in}; // R2 R3 R7
        end
    end

    // The serial output follows the bit that was just pushed into stage 21.
    always_ff @(posedge link.shift_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            data_out <= 1'h0;
        end else if (!link.load_enable_n) begin
            data_out <= shadow[`CHAIN_LEN-2]; // R8 R9
        end
    end

    assign link.serial_data_out = data_out; // R11

    // Two flip-flops bring the enable into the system domain.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            enable_n_meta <= 1'h1;
            enable_n_sync <= 1'h1;
        end else begin
            enable_n_meta <= link.load_enable_n;
            enable_n_sync <= enable_n_meta;
        end
    end

    // Edge detector on the synchronised enable.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            enable_n_prev <= 1'h1;
        end else begin
            enable_n_prev <= enable_n_sync;
        end
    end

    assign commit_now = enable_n_sync && !enable_n_prev; // R6

    // Two flip-flops bring the strap pins into the system domain.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strap_meta <= `CODES_RESET;
            strap_sync <= `CODES_RESET;
        end else begin
            strap_meta <= i_boost_strap_pins;
            strap_sync <= strap_meta;
        end
    end

    // The shadow chain is frozen while the enable stays high, so it is
    // stable by the time the synchronised rise is seen here.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            active <= `WORD_RESET; // R14
        end else if (commit_now) begin
            active <= shadow; // R6
        end
    end

    // Records that at least one programming cycle has completed.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            loaded <= 1'h0;
        end else if (commit_now) begin
            loaded <= 1'h1;
        end
    end

    // Counts completed programming cycles, wrapping at the top.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            commit_count <= '0;
        end else if (commit_now) begin
            commit_count <= commit_count + `COMMIT_CNT_W'(1);
        end
    end

    // One commit pulse per enable rise.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_commit <= 1'h0;
        end else begin
            o_commit <= commit_now;
        end
    end

    // Per channel choice between register code and strap code.
    generate
        for (genvar ch = 0; ch < `CHANNELS; ch++) begin : g_channel
            always_comb begin
                if (active[`OVERRIDE_POS]) begin // R12
                    next_boost[ch * `CODE_W +: `CODE_W] = code_of(active, ch); // R13
                    next_from_regs[ch] = 1'h1;
                end else begin
                    next_boost[ch * `CODE_W +: `CODE_W] = strap_of(strap_sync, ch);
                    next_from_regs[ch] = 1'h0;
                end
            end
        end
    endgenerate

    // The applied boost levels come from flip-flops.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            boost_level <= `CODES_RESET;
            from_regs <= '0;
        end else begin
            boost_level <= next_boost; // R12
            from_regs <= next_from_regs;
        end
    end

    assign o_boost_level = boost_level;
    assign o_boost_from_regs = from_regs;
    assign o_override = active[`OVERRIDE_POS];
    assign o_loaded = loaded;
    assign o_commit_count = commit_count;
    assign o_active_word = active;

endmodule // eq_serial_device

`default_nettype wire

// file: core/eq_serial_host.sv
`include "eq_serial_params.svh"
`timescale 1ns/100ps
`default_nettype none

module eq_serial_host (
    eq_serial_if.host link,
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire logic [`CHAIN_LEN-1:0] i_config,
    output logic o_busy,
    output logic o_done
);

    eq_serial_pkg::host_state_type state;
    eq_serial_pkg::config_word_type word;
    logic [`BIT_CNT_W-1:0] bit_cnt;
    logic [`WAIT_CNT_W-1:0] wait_cnt;
    logic enable_n;
    logic shift_clk;
    logic data;
    logic done;

    // Sequencer: enable low, 21 clocked bits, hold, enable high.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= eq_serial_pkg::HOST_IDLE;
        end else begin
            case (state)
                eq_serial_pkg::HOST_IDLE: begin
                    if (i_start) begin
                        state <= eq_serial_pkg::HOST_SETUP;
                    end
                end
                eq_serial_pkg::HOST_SETUP: begin
                    if (wait_cnt == `WAIT_CNT_W'(`SETUP_CYCLES - 1)) begin
                        state <= eq_serial_pkg::HOST_SHIFT;
                    end
                end
                eq_serial_pkg::HOST_SHIFT: begin
                    if (shift_clk && bit_cnt == `BIT_CNT_LAST) begin // R2
                        state <= eq_serial_pkg::HOST_HOLD;
                    end
                end
                eq_serial_pkg::HOST_HOLD: begin
                    if (wait_cnt == `WAIT_CNT_W'(`HOLD_CYCLES - 1)) begin
                        state <= eq_serial_pkg::HOST_RELEASE;
                    end
                end
                eq_serial_pkg::HOST_RELEASE: begin
                    state <= eq_serial_pkg::HOST_IDLE;
                end
                default: begin
                    state <= eq_serial_pkg::HOST_IDLE;
                end
            endcase
        end
    end

    // Wait counter for setup and hold phases.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wait_cnt <= '0;
        end else if (state == eq_serial_pkg::HOST_SETUP || state == eq_serial_pkg::HOST_HOLD) begin
            wait_cnt <= wait_cnt + `WAIT_CNT_W'(1);
        end else begin
            wait_cnt <= '0;
        end
    end

    // Shift clock is the system clock divided by two, so 5MHz here.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shift_clk <= 1'h0;
        end else if (state == eq_serial_pkg::HOST_SHIFT) begin
            shift_clk <= !shift_clk; // R5
        end else begin
            shift_clk <= 1'h0;
        end
    end

    // Word and bit counter; data changes only while the shift clock is low.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            word <= `WORD_RESET;
            bit_cnt <= '0;
        end else if (state == eq_serial_pkg::HOST_IDLE && i_start) begin
            word <= i_config;
            bit_cnt <= '0;
        end else if (state == eq_serial_pkg::HOST_SHIFT && shift_clk) begin
            word <= {word[`CHAIN_LEN-2:0], 1'h0};
            bit_cnt <= bit_cnt + `BIT_CNT_W'(1);
        end
    end

    // Register 21 goes out first, register 1 last.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            data <= 1'h0;
        end else if (state == eq_serial_pkg::HOST_IDLE && i_start) begin
            data <= i_config[`CHAIN_LEN-1]; // R4
        end else if (state == eq_serial_pkg::HOST_SHIFT && shift_clk) begin
            data <= word[`CHAIN_LEN-2]; // R4
        end
    end

    // One enable for this link only; it is held low for the whole frame.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            enable_n <= 1'h1;
        end else if (state == eq_serial_pkg::HOST_IDLE && i_start) begin
            enable_n <= 1'h0; // R10 R15
        end else if (state == eq_serial_pkg::HOST_RELEASE) begin
            enable_n <= 1'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            done <= 1'h0;
        end else begin
            done <= (state == eq_serial_pkg::HOST_RELEASE);
        end
    end

    assign link.load_enable_n = enable_n;
    assign link.shift_clk = shift_clk;
    assign link.serial_data_in = data;
    assign o_busy = (state != eq_serial_pkg::HOST_IDLE);
    assign o_done = done;

endmodule // eq_serial_host

`default_nettype wire

// file: tb/eq_serial_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module eq_serial_monitor (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic load_enable_n,
    input wire logic shift_clk,
    input wire logic serial_data_in,
    input wire logic serial_data_out
);
    logic [4:0] rise_cnt;
    logic sclk_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    // Counts shift clock rises within one enable-low period.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rise_cnt <= 5'h00;
            sclk_q <= 1'h0;
        end else begin
            sclk_q <= shift_clk;
            if (load_enable_n) begin
                rise_cnt <= 5'h00;
            end else if (shift_clk && !sclk_q) begin
                rise_cnt <= rise_cnt + 5'h01;
            end
        end
    end

    sequence s_setup;
        !shift_clk [*2];
    endsequence
    sequence s_rise;
        $rose(shift_clk);
    endsequence

    chk_setup_first_rise: assert property ($fell(load_enable_n) |-> s_setup ##1 s_rise)
        else $error("shift clock setup after enable fall wrong");
    chk_word_length: assert property ($rose(load_enable_n) |-> rise_cnt == 5'h15)
        else $error("frame did not carry 21 bits");
    chk_hold_before_commit: assert property ($rose(load_enable_n) |-> !shift_clk && !$past(shift_clk))
        else $error("enable rose without hold");
    chk_clock_pulse_rate: assert property ($rose(shift_clk) |=> $fell(shift_clk))
        else $error("shift clock high too long");
    chk_clock_next_rise: assert property ($fell(shift_clk) && rise_cnt < 5'h15 |=> s_rise)
        else $error("shift clock low too long");
    chk_clock_idle_high: assert property (load_enable_n && $past(load_enable_n) |-> !shift_clk)
        else $error("shift clock moved while enable high");
    chk_data_stable_edge: assert property (s_rise |-> $stable(serial_data_in))
        else $error("data changed at the sampling edge");
    chk_out_on_shift: assert property ($changed(serial_data_out) |-> s_rise and !load_enable_n)
        else $error("serial output moved without an enabled edge");
endmodule // eq_serial_monitor

`default_nettype wire

// file: tb/equalizer_serial_config_port_bench.sv
`include "eq_serial_params.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module equalizer_serial_config_port_bench;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_start = 1'b0;
    logic [20:0] i_config = 21'h000000;
    logic [19:0] strap_a = 20'h8a4c3;
    logic [19:0] strap_b = 20'h1234f;
    logic o_busy, o_done, o_override, o_commit, o_loaded, o_commit_b;
    logic [19:0] o_boost_level, lv_b;
    logic [3:0] o_boost_from_regs;
    logic [7:0] o_commit_count;
    logic [20:0] o_active_word, word_b;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;

    eq_serial_if link_a();
    eq_serial_if link_b();
    eq_serial_host eq_serial_host_inst (.link(link_a), .i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start),
        .i_config(i_config), .o_busy(o_busy), .o_done(o_done));
    eq_serial_device eq_serial_device_inst (.link(link_a), .i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_boost_strap_pins(strap_a), .o_boost_level(o_boost_level), .o_boost_from_regs(o_boost_from_regs),
        .o_override(o_override), .o_commit(o_commit), .o_loaded(o_loaded), .o_commit_count(o_commit_count),
        .o_active_word(o_active_word));
    eq_serial_device eq_serial_device_inst_b (.link(link_b), .i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_boost_strap_pins(strap_b), .o_boost_level(lv_b), .o_boost_from_regs(), .o_override(),
        .o_commit(o_commit_b), .o_loaded(), .o_commit_count(), .o_active_word(word_b));
    eq_serial_monitor eq_serial_monitor_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .load_enable_n(link_a.load_enable_n), .shift_clk(link_a.shift_clk),
        .serial_data_in(link_a.serial_data_in), .serial_data_out(link_a.serial_data_out));

    initial begin
        link_b.load_enable_n = 1'b1;
        link_b.shift_clk = 1'b0;
        link_b.serial_data_in = 1'b0;
    end

    always #50 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [19:0] exp_lv(input logic [20:0] w, input logic [19:0] p);
        return w[0] ? w[20:1] : p;
    endfunction

    task automatic start(input logic [20:0] w);
        @(posedge i_clk);
        i_start <= 1'b1;
        i_config <= w;
        @(posedge i_clk);
        i_start <= 1'b0;
    endtask

    task automatic wait_done;
        int i;
        i = 0;
        do begin
            @(negedge i_clk);
            i++;
        end while (o_done !== 1'b1 && i < 80);
        `CHECK("done", 1'b1, o_done)
    endtask

    task automatic check_commit(input logic [20:0] w);
        int i;
        i = 0;
        while (o_commit !== 1'b1 && i < 20) begin
            @(negedge i_clk);
            i++;
        end
        `CHECK("commit", 1'b1, o_commit)
        repeat (2) @(negedge i_clk);
        `CHECK("word", w, o_active_word)
        `CHECK("override", w[0], o_override)
        `CHECK("level", exp_lv(w, strap_a), o_boost_level)
        `CHECK("from_regs", {4{w[0]}}, o_boost_from_regs)
        `CHECK("loaded", 1'b1, o_loaded)
        `CHECK("dout", w[20], link_a.serial_data_out)
    endtask

    task automatic single(input logic [20:0] w);
        logic [20:0] old;
        old = o_active_word;
        start(w);
        repeat (20) @(negedge i_clk);
        `CHECK("frozen", old, o_active_word)
        wait_done();
        check_commit(w);
    endtask

    task automatic strap_follow;
        @(posedge i_clk);
        strap_a <= 20'h5b1d2;
        repeat (6) @(negedge i_clk);
        `CHECK("strap", 20'h5b1d2, o_boost_level)
    endtask

    task automatic back_to_back(input logic [20:0] w1, input logic [20:0] w2);
        logic [7:0] cnt;
        cnt = o_commit_count;
        start(w1);
        wait_done();
        start(w2);
        @(negedge i_clk);
        `CHECK("busy", 1'b1, o_busy)
        wait_done();
        check_commit(w2);
        `CHECK("count", cnt + 8'h02, o_commit_count)
    endtask

    // Drives 25 bits on the second link with an 80 ns clock; only the last 21 must remain.
    task automatic overflow_b;
        logic [24:0] s;
        int k;
        s = 25'h1b3c5a7;
        #13 link_b.load_enable_n = 1'b0;
        #40;
        for (k = 0; k < 25; k++) begin
            link_b.serial_data_in = s[24-k];
            #40 link_b.shift_clk = 1'b1;
            #1;
            if (k >= 20) begin
                `CHECK("dout_b", s[44-k], link_b.serial_data_out)
            end
            #39 link_b.shift_clk = 1'b0;
        end
        link_b.serial_data_in = ~link_b.serial_data_in;
        #40 link_b.load_enable_n = 1'b1;
        k = 0;
        while (o_commit_b !== 1'b1 && k < 20) begin
            @(negedge i_clk);
            k++;
        end
        `CHECK("commit_b", 1'b1, o_commit_b)
        repeat (2) @(negedge i_clk);
        `CHECK("word_b", s[20:0], word_b)
        `CHECK("level_b", exp_lv(s[20:0], strap_b), lv_b)
        #40 link_b.shift_clk = 1'b1;
        #40 link_b.shift_clk = 1'b0;
        repeat (4) @(negedge i_clk);
        `CHECK("still_b", s[20], link_b.serial_data_out)
        `CHECK("kept_b", s[20:0], word_b)
    endtask

    initial begin
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(negedge i_clk);
        `CHECK("rst_override", 1'b0, o_override)
        repeat (3) @(negedge i_clk);
        `CHECK("rst_level", strap_a, o_boost_level)
        single(21'h0a5c3b);
        single(21'h15a3c6);
        strap_follow();
        back_to_back(21'h1fffff, 21'h100001);
        overflow_b();
        wrap_up();
    end
endmodule // equalizer_serial_config_port_bench

`default_nettype wire
